// [rtl/spf_forward.sv]
// Operation
// - each incoming packet is looked up by destination in a programmable table and, if not local, steered to the table's outbound port.
// - every forwarding decision and every data move is made in hardware with no processor involvement.
// - forwarded packets are copied word by word from the inbound stream into the outbound buffer tagged with the egress port.
// - all packet types are forwarded, responses, maintenance, doorbells and messages included, not only requests.
// - with the defect reproduced, a forwarded response keeps only its first 16 payload bytes, the rest is dropped and a flag pulses.
// - response payloads are treated as up to 256 bytes, which is what exposes read responses to the truncation.
// - short responses such as write, maintenance, message and doorbell responses pass unchanged since they stay within the limit.
// - request packets are forwarded with their full payload, since only responses are cut.
`timescale 1ns/1ps
module spf_forward #(
   parameter bit TRUNC_EN = 1'b1,
   parameter int TRUNC_BYTES = spf_pkg::TRUNC_BYTES
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [spf_pkg::ID_W-1:0] i_local_id,
   input wire logic i_tbl_we,
   input wire logic [spf_pkg::ID_W-1:0] i_tbl_addr,
   input wire spf_pkg::spf_route_t i_tbl_entry,
   input wire logic i_in_valid,
   input wire spf_pkg::spf_in_beat_t i_in,
   output logic o_in_ready,
   output logic o_out_valid,
   output spf_pkg::spf_out_beat_t o_out,
   input wire logic i_out_ready,
   output logic o_trunc,
   output logic o_drop
);

   localparam int TABLE_DEPTH = 2 ** spf_pkg::ID_W;
   localparam logic [spf_pkg::CNT_W-1:0] TRUNC_LAST =
      spf_pkg::CNT_W'(TRUNC_BYTES / spf_pkg::BYTES_PER_WORD - 1);
   localparam logic [spf_pkg::CNT_W-1:0] MAX_LAST =
      spf_pkg::CNT_W'(spf_pkg::MAX_RESP_WORDS - 1);

   function automatic logic [spf_pkg::ID_W-1:0] dest_of(
      input logic [spf_pkg::DATA_W-1:0] hdr);
      dest_of = hdr[spf_pkg::DEST_MSB:spf_pkg::DEST_LSB];
   endfunction

   function automatic logic is_response(
      input logic [spf_pkg::DATA_W-1:0] hdr);
      is_response = hdr[spf_pkg::FTYPE_MSB:spf_pkg::FTYPE_LSB] ==
         spf_pkg::FTYPE_RESPONSE;
   endfunction

   // routing table
   logic [spf_pkg::PORT_W-1:0] tbl_port_mem [TABLE_DEPTH];
   logic [TABLE_DEPTH-1:0] tbl_valid_reg;

   always_ff @(posedge i_clk) begin
      if (i_tbl_we) begin
         tbl_port_mem[i_tbl_addr] <= i_tbl_entry.port;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tbl_valid_reg <= '0;
      end else if (i_tbl_we) begin
         tbl_valid_reg[i_tbl_addr] <= i_tbl_entry.valid;
      end
   end

   // packet state
   spf_pkg::spf_state_t state_reg, state_next;
   logic [spf_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic resp_reg, resp_next;
   logic local_reg, local_next;
   logic [spf_pkg::PORT_W-1:0] port_reg, port_next;
   logic skid_valid_reg, skid_valid_next;
   spf_pkg::spf_out_beat_t skid_reg;
   logic accept;
   logic push;
   spf_pkg::spf_out_beat_t push_beat;
   logic trunc_next;
   logic drop_next;
   logic [spf_pkg::ID_W-1:0] hdr_dest;
   logic hdr_local;
   logic hdr_routed;

   assign accept = i_in_valid & o_in_ready;
   assign hdr_dest = dest_of(i_in.data);
   assign hdr_local = hdr_dest == i_local_id;
   assign hdr_routed = tbl_valid_reg[hdr_dest];

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      resp_next = resp_reg;
      local_next = local_reg;
      port_next = port_reg;
      push = 1'b0;
      push_beat.data = i_in.data;
      push_beat.sof = i_in.sof;
      push_beat.eof = i_in.eof;
      push_beat.to_local = local_reg;
      push_beat.port = port_reg;
      trunc_next = 1'b0;
      drop_next = 1'b0;
      if (accept) begin
         case (state_reg)
            spf_pkg::SPF_IDLE: begin
               if (i_in.sof && (hdr_local || hdr_routed)) begin
                  // local hit wins over any table entry
                  local_next = hdr_local;
                  // local packets carry port zero, never an unwritten entry
                  port_next = hdr_local ? '0 : tbl_port_mem[hdr_dest];
                  resp_next = is_response(i_in.data);
                  cnt_next = spf_pkg::CNT_ZERO;
                  push = 1'b1;
                  push_beat.to_local = hdr_local;
                  push_beat.port = port_next;
                  if (!i_in.eof) begin
                     state_next = spf_pkg::SPF_PASS;
                  end
               end else begin
                  // no route, or stray payload word
                  drop_next = 1'b1;
                  if (!i_in.eof) begin
                     state_next = spf_pkg::SPF_DISCARD;
                  end
               end
            end
            spf_pkg::SPF_PASS: begin
               push = 1'b1;
               push_beat.sof = 1'b0;
               if (cnt_reg != MAX_LAST) begin
                  cnt_next = cnt_reg + spf_pkg::CNT_ONE;
               end
               if (i_in.eof) begin
                  state_next = spf_pkg::SPF_IDLE;
               end else if (TRUNC_EN && resp_reg && !local_reg &&
                            cnt_reg == TRUNC_LAST) begin
                  // only forwarded responses beyond the limit are cut
                  push_beat.eof = 1'b1;
                  trunc_next = 1'b1;
                  state_next = spf_pkg::SPF_DISCARD;
               end
            end
            spf_pkg::SPF_DISCARD: begin
               if (i_in.eof) begin
                  state_next = spf_pkg::SPF_IDLE;
               end
            end
            default: begin
               state_next = spf_pkg::SPF_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= spf_pkg::SPF_IDLE;
         cnt_reg <= spf_pkg::CNT_ZERO;
         resp_reg <= 1'b0;
         local_reg <= 1'b0;
         port_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         resp_reg <= resp_next;
         local_reg <= local_next;
         port_reg <= port_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_trunc <= 1'b0;
         o_drop <= 1'b0;
      end else begin
         o_trunc <= trunc_next;
         o_drop <= drop_next;
      end
   end

   // two-entry output buffer: output register plus skid register
   always_comb begin
      skid_valid_next = skid_valid_reg;
      if (skid_valid_reg && (!o_out_valid || i_out_ready)) begin
         skid_valid_next = 1'b0;
      end else if (push && o_out_valid && !i_out_ready) begin
         skid_valid_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         skid_valid_reg <= 1'b0;
         o_in_ready <= 1'b0;
      end else begin
         skid_valid_reg <= skid_valid_next;
         o_in_ready <= !skid_valid_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         skid_reg <= '0;
      end else if (push && o_out_valid && !i_out_ready) begin
         skid_reg <= push_beat;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_out_valid <= 1'b0;
         o_out <= '0;
      end else if (!o_out_valid || i_out_ready) begin
         if (skid_valid_reg) begin
            o_out_valid <= 1'b1;
            o_out <= skid_reg;
         end else begin
            o_out_valid <= push;
            o_out <= push_beat;
         end
      end
   end

endmodule

// [rtl/spf_pkg.sv]
package spf_pkg;

   localparam int DATA_W = 32;
   localparam int ID_W = 8;
   localparam int PORT_W = 2;
   localparam int FTYPE_W = 4;
   localparam int TTYPE_W = 4;
   localparam int CNT_W = 7;

   // header word layout
   localparam int DEST_MSB = 31;
   localparam int DEST_LSB = 24;
   localparam int FTYPE_MSB = 23;
   localparam int FTYPE_LSB = 20;
   localparam int TTYPE_MSB = 19;
   localparam int TTYPE_LSB = 16;

   localparam logic [FTYPE_W-1:0] FTYPE_RESPONSE = 4'hd;
   localparam logic [TTYPE_W-1:0] TTYPE_RESP_DATA = 4'h8;

   localparam int BYTES_PER_WORD = 4;
   localparam int TRUNC_BYTES = 16;
   localparam int MAX_RESP_BYTES = 256;
   localparam int TRUNC_WORDS = TRUNC_BYTES / BYTES_PER_WORD;
   localparam int MAX_RESP_WORDS = MAX_RESP_BYTES / BYTES_PER_WORD;

   localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic sof;
      logic eof;
   } spf_in_beat_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic sof;
      logic eof;
      logic to_local;
      logic [PORT_W-1:0] port;
   } spf_out_beat_t;

   typedef struct packed {
      logic valid;
      logic [PORT_W-1:0] port;
   } spf_route_t;

   typedef enum logic [1:0] {
      SPF_IDLE,
      SPF_PASS,
      SPF_DISCARD
   } spf_state_t;

endpackage

// [verif/spf_forward_assertions.sv]
`timescale 1ns/1ps
module spf_chk #(
   parameter bit TRUNC_EN = 1'b1,
   parameter int TRUNC_BYTES = spf_pkg::TRUNC_BYTES
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [spf_pkg::ID_W-1:0] i_local_id,
   input wire logic i_in_valid,
   input wire spf_pkg::spf_in_beat_t i_in,
   input wire logic o_in_ready,
   input wire logic o_out_valid,
   input wire spf_pkg::spf_out_beat_t o_out,
   input wire logic i_out_ready,
   input wire logic o_trunc,
   input wire logic o_drop
);
   localparam int TW = TRUNC_BYTES / 4;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   logic resp_reg;
   logic [6:0] cnt_reg;
   wire mv = o_out_valid && i_out_ready;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) resp_reg <= 1'b0;
      else if (mv && o_out.sof) resp_reg <= !o_out.to_local &&
         o_out.data[23:20] == spf_pkg::FTYPE_RESPONSE;
   end
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) cnt_reg <= 7'h00;
      else if (mv) cnt_reg <= o_out.sof ? 7'h00 : cnt_reg + 7'h01;
   end
   sequence stall_s;
      o_out_valid && !i_out_ready;
   endsequence
   sequence idle_s;
      !o_out_valid ##1 !o_out_valid;
   endsequence
   out_hold_a: assert property (stall_s |=> $stable(o_out) && o_out_valid)
      else $error("outbound beat changed while stalled");
   in_ready_a: assert property (idle_s |-> o_in_ready)
      else $error("inbound not ready with empty output");
   local_first_a: assert property (i_in_valid && o_in_ready && i_in.sof &&
      i_in.data[31:24] == i_local_id && !o_out_valid |=> o_out_valid && o_out.to_local)
      else $error("local packet not delivered locally");
   local_wins_a: assert property (o_out_valid && o_out.sof &&
      o_out.data[31:24] == i_local_id |-> o_out.to_local)
      else $error("local header sent to a port");
   remote_port_a: assert property (o_out_valid && o_out.sof &&
      o_out.data[31:24] != i_local_id |-> !o_out.to_local)
      else $error("remote header delivered locally");
   trunc_len_a: assert property (TRUNC_EN && o_out_valid && resp_reg &&
      !o_out.sof |-> cnt_reg < TW)
      else $error("forwarded response too long");
   trunc_eof_a: assert property (TRUNC_EN && o_out_valid && resp_reg &&
      !o_out.sof && cnt_reg == TW - 1 |-> o_out.eof)
      else $error("cut response lacks end mark");
   pulse_once_a: assert property (o_trunc || o_drop |=> !o_trunc && !o_drop)
      else $error("flag held past one cycle");
endmodule
bind spf_forward spf_chk #(.TRUNC_EN(TRUNC_EN), .TRUNC_BYTES(TRUNC_BYTES)) chk (
   .i_clk(i_clk), .i_reset(i_reset), .i_local_id(i_local_id),
   .i_in_valid(i_in_valid), .i_in(i_in), .o_in_ready(o_in_ready),
   .o_out_valid(o_out_valid), .o_out(o_out), .i_out_ready(i_out_ready),
   .o_trunc(o_trunc), .o_drop(o_drop));

// [verif/spf_sink.sv]
`timescale 1ns/1ps
module spf_sink (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_valid,
   input wire spf_pkg::spf_out_beat_t i_beat,
   input wire logic i_slow,
   output logic o_ready
);
   spf_pkg::spf_out_beat_t got[$];
   // slow mode stalls every other cycle
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_ready <= 1'b0;
      end else begin
         if (i_valid && o_ready) got.push_back(i_beat);
         o_ready <= i_slow ? ~o_ready : 1'b1;
      end
   end
endmodule

// [verif/srio_packet_forwarding_tb.sv]
`timescale 1ns/1ps
module srio_packet_forwarding_tb;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [7:0] i_local_id = 8'h05;
   logic i_tbl_we = 1'b0;
   logic [7:0] i_tbl_addr = 8'h00;
   spf_pkg::spf_route_t i_tbl_entry = '0;
   logic i_in_valid = 1'b0;
   spf_pkg::spf_in_beat_t i_in = '0;
   logic o_in_ready, o_out_valid, i_out_ready, o_trunc, o_drop;
   logic slow = 1'b0;
   spf_pkg::spf_out_beat_t o_out;
   int bad_count = 0, samples_checked = 0, cyc = 0, n_tr = 0, n_dr = 0;
   always #20 i_clk = ~i_clk;
   spf_forward uut (.i_clk(i_clk), .i_reset(i_reset), .i_local_id(i_local_id),
      .i_tbl_we(i_tbl_we), .i_tbl_addr(i_tbl_addr), .i_tbl_entry(i_tbl_entry),
      .i_in_valid(i_in_valid), .i_in(i_in), .o_in_ready(o_in_ready),
      .o_out_valid(o_out_valid), .o_out(o_out), .i_out_ready(i_out_ready),
      .o_trunc(o_trunc), .o_drop(o_drop));
   spf_sink sink (.i_clk(i_clk), .i_reset(i_reset), .i_valid(o_out_valid),
      .i_beat(o_out), .i_slow(slow), .o_ready(i_out_ready));
   always @(posedge i_clk) begin
      if (o_trunc === 1'b1) n_tr++;
      if (o_drop === 1'b1) n_dr++;
      if (cyc++ == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [31:0] hdr(input logic [7:0] f);
      return {f[7] ? 8'h05 : 8'h21, f[3:0], 20'h0_0000};
   endfunction
   function automatic logic [31:0] wd(input int i, input logic [31:0] h);
      return i == 0 ? h : 32'h1000_0000 + 32'(i);
   endfunction
   task automatic send(input logic [31:0] h, input int n);
      for (int i = 0; i <= n; i++) begin
         i_in_valid = 1'b1;
         i_in = {wd(i, h), i == 0, i == n};
         while (o_in_ready !== 1'b1) @(posedge i_clk) #1;
         @(posedge i_clk) #1;
      end
      i_in_valid = 1'b0;
   endtask
   task automatic expect_pkt(input logic [31:0] h, input int n, input logic lc);
      for (int k = 0; k < 300 && sink.got.size() < n + 1; k++) @(posedge i_clk) #1;
      repeat (4) @(posedge i_clk) #1;
      check(sink.got.size(), n + 1);
      for (int i = 0; i < sink.got.size() && i <= n; i++)
         check({sink.got[i][36:2], lc ? 2'h0 : sink.got[i].port},
            {wd(i, h), i == 0, i == n, lc, lc ? 2'h0 : 2'h2});
      sink.got.delete();
   endtask
   task automatic t_local();
      send(hdr(8'h85), 2);
      expect_pkt(hdr(8'h85), 2, 1'b1);
      $display("test local done");
   endtask
   task automatic t_request();
      slow = 1'b1;
      send(hdr(8'h05), 8);
      expect_pkt(hdr(8'h05), 8, 1'b0);
      slow = 1'b0;
      $display("test request done");
   endtask
   task automatic t_long_resp();
      n_tr = 0;
      send(hdr(8'h0D), 64);
      expect_pkt(hdr(8'h0D), 4, 1'b0);
      check(n_tr, 1);
      $display("test long response done");
   endtask
   task automatic t_types();
      logic [7:0] f[4] = '{8'h08, 8'h0A, 8'h0B, 8'h0D};
      n_tr = 0;
      foreach (f[j]) begin
         send(hdr(f[j]), 4);
         expect_pkt(hdr(f[j]), 4, 1'b0);
      end
      check(n_tr, 0);
      $display("test types done");
   endtask
   task automatic t_noroute();
      n_dr = 0;
      send({8'h33, 24'h50_0000}, 3);
      repeat (6) @(posedge i_clk) #1;
      check(sink.got.size(), 0);
      check(n_dr, 1);
      $display("test no route done");
   endtask
   initial begin
      repeat (5) @(posedge i_clk);
      #1 i_reset = 1'b0;
      i_tbl_we = 1'b1;
      i_tbl_addr = 8'h21;
      i_tbl_entry = {1'b1, 2'h2};
      @(posedge i_clk) #1;
      i_tbl_we = 1'b0;
      t_local();
      t_request();
      t_long_resp();
      t_types();
      t_noroute();
      report_and_stop();
   end
endmodule
